// ===== verilog/cdbt_regs.svh
// Offsets, field positions, reset values and counts of the debug block.
`ifndef CDBT_REGS_SVH
`define CDBT_REGS_SVH
// =====================================================================
// Register indices
`define CDBT_IDX_ADDR      4'h0
`define CDBT_IDX_ADDR_MASK 4'h1
`define CDBT_IDX_DATA      4'h2
`define CDBT_IDX_DATA_MASK 4'h3
`define CDBT_IDX_PC0       4'h4
`define CDBT_IDX_PC_MASK   4'h8
`define CDBT_IDX_CTRL      4'h9
`define CDBT_IDX_STATUS    4'ha
`define CDBT_IDX_CRIT      4'hb
`define CDBT_NUM_BP        9
// =====================================================================
// Trigger control fields
`define CDBT_CTRL_L1_LSB   0
`define CDBT_CTRL_L2_LSB   3
`define CDBT_CTRL_TWO_LVL  6
`define CDBT_CTRL_RESP_IRQ 7
`define CDBT_CTRL_ARM      8
`define CDBT_CTRL_RST      32'h0000_0000
`define CDBT_CRIT_RST      3'h7
// =====================================================================
// Serial frame and trace codes
`define CDBT_FRAME_BITS    6'h25
`define CDBT_FRAME_LAST    6'h24
`define CDBT_PST_HALT      4'hf
`define CDBT_PST_DATA      4'h8
`define CDBT_PST_IDLE      4'h0
`define CDBT_NIB_LAST      3'h7
`endif

// ===== verilog/cdbt_pkg.sv
// Types shared by the debug block modules.
package cdbt_pkg;
  typedef enum logic [1:0] {
    CDBT_IDLE = 2'b00,
    CDBT_LVL1 = 2'b01,
    CDBT_LVL2 = 2'b10,
    CDBT_DONE = 2'b11
  } cdbt_trig_t;
  typedef logic [31:0] cdbt_word_t;
  typedef logic [3:0]  cdbt_idx_t;
endpackage

// ===== verilog/cdbt_stream_if.sv
// Valid/ready word stream used between the debug block modules.
`timescale 1ns/1ps
interface cdbt_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // cdbt_stream_if

// ===== verilog/cdbt_match.sv
// Masked comparator: a set mask bit excludes that bit from the match.
`timescale 1ns/1ps
module cdbt_match (
  input  wire logic [31:0] value,
  input  wire logic [31:0] ref_val,
  input  wire logic [31:0] mask,
  output logic             hit
);
  assign hit = (((value ^ ref_val) & ~mask) == 32'h0000_0000);
endmodule // cdbt_match

// ===== verilog/cdbt_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module cdbt_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic   mclk,
  input  wire logic   arst_n,
  cdbt_stream_if.snk  in_s,
  cdbt_stream_if.src  out_s
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [0:D-1];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  wire          full  = (wr_q[AW] != rd_q[AW]) &&
                        (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire          empty = (wr_q == rd_q);
  wire          push  = in_s.valid && !full;
  wire          pop   = out_s.ready && !empty;

  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // Storage has no reset; only the pointers decide what is valid.
  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_s.data;
  end
endmodule // cdbt_fifo

// ===== verilog/cdbt_core_debug.sv
// Core debug unit: breakpoints, triggers, serial access and trace port.
// Notes on behaviour
// - Nine 32-bit breakpoint registers, four PC values.
// - Registers reachable by serial tool and supervisor.
// - Address, data, PC matches form one/two-level triggers.
// - Trigger halts core or raises debug interrupt.
// - Critical interrupts still serviced during debug interrupt.
// - Drive status nibble, data nibble and trace clock.
// - All-status output is AND of status bits.
// - Status shows 1111 while the core is halted.
// - Serial channel always present; trace buses optional.
`timescale 1ns/1ps
`include "cdbt_regs.svh"
module cdbt_core_debug #(
  parameter bit FULL_TRACE = 1'b1
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             dbg_serial_in,
  input  wire logic             dbg_serial_clock,
  output logic                  dbg_serial_out,
  input  wire cdbt_pkg::cdbt_word_t cpu_addr,
  input  wire logic             cpu_addr_valid,
  input  wire cdbt_pkg::cdbt_word_t cpu_data,
  input  wire logic             cpu_data_valid,
  input  wire cdbt_pkg::cdbt_word_t cpu_pc,
  input  wire logic             cpu_pc_valid,
  input  wire logic             cpu_supervisor,
  input  wire logic             cpu_reg_wr,
  input  wire logic             cpu_reg_rd,
  input  wire cdbt_pkg::cdbt_idx_t cpu_reg_idx,
  input  wire cdbt_pkg::cdbt_word_t cpu_reg_wdata,
  output cdbt_pkg::cdbt_word_t  cpu_reg_rdata,
  input  wire logic             cpu_halted,
  input  wire logic [3:0]       cpu_status,
  input  wire logic             dbg_irq_active,
  input  wire logic [2:0]       cpu_irq_level,
  output logic                  irq_allow,
  output logic                  halt_req,
  output logic                  dbg_irq_req,
  input  wire logic             trace_valid,
  input  wire cdbt_pkg::cdbt_word_t trace_word,
  output logic                  trace_ready,
  output logic [3:0]            proc_status_bus,
  output logic [3:0]            trace_data_bus,
  output logic                  trace_clock_out,
  output logic                  all_status_high
);
  import cdbt_pkg::*;

  // ===================================================================
  // Serial link input synchronisers and edge detection
  logic [1:0] sclk_sync_q;
  logic [1:0] sin_sync_q;
  logic       sclk_prev_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // The tool parks its clock high between frames; resetting to that
      // level keeps a false rising edge from shifting a stray bit.
      sclk_sync_q <= 2'b11;
      sin_sync_q  <= 2'b00;
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], dbg_serial_clock};
      sin_sync_q  <= {sin_sync_q[0], dbg_serial_in};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  wire sclk_rise = sclk_sync_q[1] && !sclk_prev_q;
  wire sclk_fall = !sclk_sync_q[1] && sclk_prev_q;

  // ===================================================================
  // Serial frame: write flag, index, 32 data bits, MSB first
  logic [35:0] sh_q;
  logic [5:0]  bit_cnt_q;
  logic [31:0] obuf_q;
  logic        sout_q;

  wire [36:0] frame     = {sh_q, sin_sync_q[1]};
  wire        frame_end = sclk_rise && (bit_cnt_q == `CDBT_FRAME_LAST);
  wire        ser_we    = frame_end && frame[36];
  wire [3:0]  ser_idx   = frame[35:32];
  wire [31:0] ser_wdata = frame[31:0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q      <= '0;
      bit_cnt_q <= 6'h00;
    end else if (sclk_rise) begin
      sh_q      <= frame[35:0];
      bit_cnt_q <= frame_end ? 6'h00 : bit_cnt_q + 6'h01;
    end
  end

  // ===================================================================
  // Breakpoint and control registers
  cdbt_word_t bp_q [0:`CDBT_NUM_BP-1];
  cdbt_word_t ctrl_q;
  logic [2:0] crit_q;
  logic       fired_q;
  cdbt_trig_t st_q;
  cdbt_trig_t st_d;

  // The serial tool wins a same-cycle collision; the core write is lost.
  wire        cpu_we   = cpu_reg_wr && cpu_supervisor && !ser_we;
  wire        any_we   = ser_we || cpu_we;
  wire [3:0]  w_idx    = ser_we ? ser_idx : cpu_reg_idx;
  wire [31:0] w_data   = ser_we ? ser_wdata : cpu_reg_wdata;
  wire        ctrl_we  = any_we && (w_idx == `CDBT_IDX_CTRL);

  function automatic cdbt_word_t rd_val(input cdbt_idx_t idx);
    cdbt_word_t v;
    v = 32'h0000_0000;
    if (idx < `CDBT_IDX_CTRL)
      v = bp_q[idx];
    else if (idx == `CDBT_IDX_CTRL)
      v = ctrl_q;
    else if (idx == `CDBT_IDX_STATUS)
      v = {29'h0, fired_q, st_q};
    else if (idx == `CDBT_IDX_CRIT)
      v = {29'h0, crit_q};
    return v;
  endfunction

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `CDBT_NUM_BP; i++) begin
        bp_q[i] <= 32'h0000_0000;
      end
      ctrl_q <= `CDBT_CTRL_RST;
      crit_q <= `CDBT_CRIT_RST;
    end else if (any_we) begin
      if (w_idx < `CDBT_IDX_CTRL) bp_q[w_idx] <= w_data;
      if (ctrl_we) ctrl_q <= w_data;
      if (w_idx == `CDBT_IDX_CRIT) crit_q <= w_data[2:0];
    end
  end

  // Read data for the tool is loaded at frame end and shifted out
  // on the falling edges of the next frame.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      obuf_q        <= 32'h0000_0000;
      sout_q        <= 1'b0;
      cpu_reg_rdata <= 32'h0000_0000;
    end else begin
      if (frame_end && !frame[36])
        obuf_q <= rd_val(ser_idx);
      else if (sclk_fall) begin
        sout_q <= obuf_q[31];
        obuf_q <= {obuf_q[30:0], 1'b0};
      end
      if (cpu_reg_rd && cpu_supervisor)
        cpu_reg_rdata <= rd_val(cpu_reg_idx);
    end
  end

  assign dbg_serial_out = sout_q;

  // ===================================================================
  // Comparators
  logic       addr_hit;
  logic       data_hit;
  logic [3:0] pc_hits;

  cdbt_match u_addr (
    .value   (cpu_addr),
    .ref_val (bp_q[`CDBT_IDX_ADDR]),
    .mask    (bp_q[`CDBT_IDX_ADDR_MASK]),
    .hit     (addr_hit)
  );
  cdbt_match u_data (
    .value   (cpu_data),
    .ref_val (bp_q[`CDBT_IDX_DATA]),
    .mask    (bp_q[`CDBT_IDX_DATA_MASK]),
    .hit     (data_hit)
  );
  for (genvar g = 0; g < 4; g++) begin : g_pc
    cdbt_match u_pc (
      .value   (cpu_pc),
      .ref_val (bp_q[`CDBT_IDX_PC0 + g]),
      .mask    (bp_q[`CDBT_IDX_PC_MASK]),
      .hit     (pc_hits[g])
    );
  end

  wire [2:0] hits = {cpu_pc_valid && (pc_hits != 4'h0),
                     cpu_data_valid && data_hit,
                     cpu_addr_valid && addr_hit};
  wire [2:0] l1_en = ctrl_q[`CDBT_CTRL_L1_LSB +: 3];
  wire [2:0] l2_en = ctrl_q[`CDBT_CTRL_L2_LSB +: 3];
  // Every enabled condition must hold; no enables means no trigger.
  wire l1_hit = (l1_en != 3'h0) && ((hits & l1_en) == l1_en);
  wire l2_hit = (l2_en != 3'h0) && ((hits & l2_en) == l2_en);
  wire two_lvl  = ctrl_q[`CDBT_CTRL_TWO_LVL];
  wire resp_irq = ctrl_q[`CDBT_CTRL_RESP_IRQ];

  // ===================================================================
  // Trigger sequencer
  logic fire;

  always_comb begin
    st_d = st_q;
    fire = 1'b0;
    case (st_q)
      CDBT_IDLE: st_d = CDBT_IDLE;
      CDBT_LVL1: begin
        if (l1_hit) begin
          st_d = two_lvl ? CDBT_LVL2 : CDBT_DONE;
          fire = !two_lvl;
        end
      end
      CDBT_LVL2: begin
        if (l2_hit) begin
          st_d = CDBT_DONE;
          fire = 1'b1;
        end
      end
      CDBT_DONE: st_d = CDBT_DONE;
      default:   st_d = CDBT_IDLE;
    endcase
  end

  // A control write re-arms or disarms; a fire in the same cycle still
  // leaves the fired flag set.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q        <= CDBT_IDLE;
      fired_q     <= 1'b0;
      halt_req    <= 1'b0;
      dbg_irq_req <= 1'b0;
    end else begin
      if (ctrl_we)
        st_q <= w_data[`CDBT_CTRL_ARM] ? CDBT_LVL1 : CDBT_IDLE;
      else
        st_q <= st_d;
      fired_q     <= fire || (fired_q && !ctrl_we);
      halt_req    <= fire && !resp_irq;
      dbg_irq_req <= fire && resp_irq;
    end
  end

  // Levels at or above the critical level still reach the core.
  assign irq_allow = !dbg_irq_active || (cpu_irq_level >= crit_q);

  // ===================================================================
  // Trace path: captured words pass a FIFO and leave a nibble per beat
  cdbt_stream_if #(.W(32)) tin_s ();
  cdbt_stream_if #(.W(32)) tout_s ();

  cdbt_fifo #(.W(32), .D(16)) u_fifo (
    .mclk   (mclk),
    .arst_n (arst_n),
    .in_s   (tin_s),
    .out_s  (tout_s)
  );

  assign tin_s.valid = trace_valid;
  assign tin_s.data  = trace_word;
  // The core must hold a capture while this is low.
  assign trace_ready = tin_s.ready;

  logic        tclk_q;
  logic        busy_q;
  logic [2:0]  nib_q;
  logic [31:0] word_q;
  logic [3:0]  pst_q;
  logic [3:0]  ddat_q;

  // Trace beats run at half the clock; a beat ends where tclk falls.
  wire tick = tclk_q;
  assign tout_s.ready = tick && !busy_q;
  wire [3:0] pst_run = (cpu_status == `CDBT_PST_HALT) ? `CDBT_PST_IDLE
                                                      : cpu_status;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tclk_q <= 1'b0;
      busy_q <= 1'b0;
      nib_q  <= 3'h0;
      word_q <= 32'h0000_0000;
      pst_q  <= `CDBT_PST_IDLE;
      ddat_q <= 4'h0;
    end else begin
      tclk_q <= !tclk_q;
      if (tick) begin
        if (busy_q) begin
          ddat_q <= word_q[31:28];
          word_q <= {word_q[27:0], 4'h0};
          nib_q  <= nib_q + 3'h1;
          busy_q <= (nib_q != `CDBT_NIB_LAST);
        end else if (tout_s.valid) begin
          word_q <= tout_s.data;
          busy_q <= 1'b1;
          nib_q  <= 3'h0;
        end
        if (cpu_halted)
          pst_q <= `CDBT_PST_HALT;
        else
          pst_q <= busy_q ? `CDBT_PST_DATA : pst_run;
      end else if (cpu_halted) begin
        pst_q <= `CDBT_PST_HALT;
      end
    end
  end

  // Only the all-status pin survives in the small configuration.
  assign proc_status_bus = FULL_TRACE ? pst_q : 4'h0;
  assign trace_data_bus  = FULL_TRACE ? ddat_q : 4'h0;
  assign trace_clock_out = FULL_TRACE ? tclk_q : 1'b0;
  assign all_status_high = &pst_q;
endmodule // cdbt_core_debug

// ===== tb/cdbt_checker.sv
// Concurrent checks on the ports of the core debug unit.
`timescale 1ns/1ps
module cdbt_checker (
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic                 cpu_supervisor,
  input wire logic                 cpu_reg_wr,
  input wire logic                 cpu_reg_rd,
  input wire cdbt_pkg::cdbt_idx_t  cpu_reg_idx,
  input wire cdbt_pkg::cdbt_word_t cpu_reg_wdata,
  input wire cdbt_pkg::cdbt_word_t cpu_reg_rdata,
  input wire logic                 cpu_halted,
  input wire logic                 dbg_irq_active,
  input wire logic [2:0]           cpu_irq_level,
  input wire logic                 irq_allow,
  input wire logic                 halt_req,
  input wire logic                 dbg_irq_req,
  input wire logic [3:0]           proc_status_bus,
  input wire logic                 trace_clock_out,
  input wire logic                 all_status_high
);
  import cdbt_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ====================================================================
  // Register access
  sequence s_wr0;
    cpu_reg_wr && cpu_supervisor && cpu_reg_idx == 4'h0;
  endsequence
  sequence s_rd0;
    cpu_reg_rd && cpu_supervisor && cpu_reg_idx == 4'h0;
  endsequence
  property p_rdback;
    s_wr0 ##1 s_rd0 |=> cpu_reg_rdata == $past(cpu_reg_wdata, 2);
  endproperty
  a_rdback: assert property (p_rdback)
    else $error("read back differs from write");
  // ====================================================================
  // Triggers and interrupts
  property p_hpulse;
    halt_req |=> !halt_req;
  endproperty
  a_hpulse: assert property (p_hpulse)
    else $error("halt request longer than one cycle");
  property p_ipulse;
    dbg_irq_req |=> !dbg_irq_req;
  endproperty
  a_ipulse: assert property (p_ipulse)
    else $error("debug irq request longer than one cycle");
  property p_excl;
    !(halt_req && dbg_irq_req);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both responses at once");
  property p_free;
    !dbg_irq_active |-> irq_allow;
  endproperty
  a_free: assert property (p_free)
    else $error("interrupt blocked outside debug");
  property p_crit;
    cpu_irq_level == 3'h7 |-> irq_allow;
  endproperty
  a_crit: assert property (p_crit)
    else $error("top level interrupt blocked");
  // ====================================================================
  // Trace port
  property p_halt;
    cpu_halted [*3] |-> proc_status_bus == 4'hf;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halted core not shown as all ones");
  property p_allst;
    all_status_high == &proc_status_bus;
  endproperty
  a_allst: assert property (p_allst)
    else $error("all-status output wrong");
  property p_tclk;
    1'b1 |=> $changed(trace_clock_out);
  endproperty
  a_tclk: assert property (p_tclk)
    else $error("trace clock did not toggle");
endmodule // cdbt_checker

bind cdbt_core_debug cdbt_checker cdbt_checker_i (.*);

// ===== tb/cdbt_tool_model.sv
// Model of the external debug tool on the serial channel.
`timescale 1ns/1ps
module cdbt_tool_model (
  input  wire logic mclk,
  output logic      dbg_serial_clock,
  output logic      dbg_serial_in,
  input  wire logic dbg_serial_out
);
  initial begin
    dbg_serial_clock = 1'b1;
    dbg_serial_in    = 1'b0;
  end
  // ====================================================================
  // One frame: 37 bits MSB first, 800 ns per bit; the out line carries
  // what the previous read frame loaded, so reads need a second frame.
  task automatic frame(input logic wr, input logic [3:0] idx,
                       input logic [31:0] d, output logic [31:0] q);
    logic [36:0] f;
    f = {wr, idx, d};
    for (int i = 36; i >= 0; i--) begin
      @(negedge mclk);
      dbg_serial_clock = 1'b0;
      dbg_serial_in = f[i];
      repeat (4) @(negedge mclk);
      if (i >= 5) q[i-5] = dbg_serial_out;
      dbg_serial_clock = 1'b1;
      repeat (3) @(negedge mclk);
    end
    // The line has no pull, so never leave the last bit standing.
    dbg_serial_in = ~dbg_serial_in;
  endtask
endmodule // cdbt_tool_model

// ===== tb/cdbt_core_debug_test.sv
// Self-checking bench of the core debug unit.
`timescale 1ns/1ps
module cdbt_core_debug_test;
  import cdbt_pkg::*;
  logic       mclk, arst_n, dbg_serial_in, dbg_serial_clock, dbg_serial_out;
  logic       cpu_addr_valid, cpu_data_valid, cpu_pc_valid, cpu_supervisor;
  logic       cpu_reg_wr, cpu_reg_rd, cpu_halted, dbg_irq_active, trace_valid;
  logic       irq_allow, halt_req, dbg_irq_req, trace_ready;
  logic       trace_clock_out, all_status_high;
  logic [2:0] cpu_irq_level;
  logic [3:0] cpu_status, proc_status_bus, trace_data_bus;
  cdbt_idx_t  cpu_reg_idx;
  cdbt_word_t cpu_addr, cpu_data, cpu_pc, cpu_reg_wdata, cpu_reg_rdata;
  cdbt_word_t trace_word;
  int         num_errors = 0, compares = 0, cycles = 0;

  cdbt_core_debug cdbt_core_debug_i (.*);
  cdbt_tool_model cdbt_tool_model_i (.*);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      end_of_test;
    end
  end
  // ====================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes stay as set until the next call, so calls may follow back to
  // back without a signal being assigned twice in one step.
  task automatic acc(input logic w, r, input logic [3:0] i,
                     input logic [31:0] d);
    cpu_reg_wr = w;
    cpu_reg_rd = r;
    cpu_reg_idx = i;
    cpu_reg_wdata = d;
    @(negedge mclk);
  endtask
  task automatic watch(input logic [1:0] exp);
    logic [1:0] got;
    got = 2'h0;
    repeat (6) begin
      @(negedge mclk);
      got = got | {dbg_irq_req, halt_req};
    end
    chk({30'h0, got}, {30'h0, exp});
  endtask
  // ====================================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 12; i++) begin
      acc(1'b0, 1'b1, 4'(i), 32'h0);
      chk(cpu_reg_rdata, (i == 11) ? 32'h7 : 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 1'b0, 4'(i), 32'ha5a5_0000 + 32'(i));
      acc(1'b0, 1'b1, 4'(i), 32'h0);
      chk(cpu_reg_rdata, 32'ha5a5_0000 + 32'(i));
    end
    cpu_supervisor = 1'b0;
    acc(1'b1, 1'b0, 4'h0, 32'h0);
    cpu_supervisor = 1'b1;
    acc(1'b1, 1'b0, 4'hc, 32'h1);
    acc(1'b0, 1'b1, 4'h0, 32'h0);
    chk(cpu_reg_rdata, 32'ha5a5_0000);
    acc(1'b0, 1'b1, 4'hc, 32'h0);
    chk(cpu_reg_rdata, 32'h0);
    acc(1'b0, 1'b0, 4'h0, 32'h0);
  endtask
  task automatic t_serial;
    logic [31:0] q;
    cdbt_tool_model_i.frame(1'b1, 4'h5, 32'h1357_9bdf, q);
    repeat (4) @(negedge mclk);
    acc(1'b0, 1'b1, 4'h5, 32'h0);
    chk(cpu_reg_rdata, 32'h1357_9bdf);
    acc(1'b1, 1'b0, 4'h3, 32'hc0de_0042);
    acc(1'b0, 1'b0, 4'h0, 32'h0);
    cdbt_tool_model_i.frame(1'b0, 4'h3, 32'h0, q);
    cdbt_tool_model_i.frame(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'hc0de_0042);
  endtask
  task automatic t_trig;
    acc(1'b1, 1'b0, 4'h0, 32'h1000_0000);
    acc(1'b1, 1'b0, 4'h1, 32'h0000_00ff);
    acc(1'b1, 1'b0, 4'h9, 32'h0000_0101);
    acc(1'b0, 1'b0, 4'h0, 32'h0);
    cpu_addr = 32'h1000_0100;
    cpu_addr_valid = 1'b1;
    watch(2'h0);
    cpu_addr = 32'h1000_00ab;
    watch(2'h1);
    cpu_addr_valid = 1'b0;
    acc(1'b0, 1'b1, 4'ha, 32'h0);
    chk(cpu_reg_rdata, 32'h7);
    // Two levels: a PC hit must come before the data hit counts.
    acc(1'b1, 1'b0, 4'h6, 32'h0000_4000);
    acc(1'b1, 1'b0, 4'h8, 32'h0);
    acc(1'b1, 1'b0, 4'h2, 32'hdead_beef);
    acc(1'b1, 1'b0, 4'h3, 32'h0);
    acc(1'b1, 1'b0, 4'h9, 32'h0000_01d4);
    acc(1'b0, 1'b0, 4'h0, 32'h0);
    cpu_data = 32'hdead_beef;
    cpu_data_valid = 1'b1;
    cpu_pc = 32'h0000_4000;
    watch(2'h0);
    cpu_pc_valid = 1'b1;
    watch(2'h2);
    {cpu_pc_valid, cpu_data_valid} = 2'h0;
  endtask
  task automatic t_irq;
    acc(1'b1, 1'b0, 4'hb, 32'h5);
    acc(1'b0, 1'b0, 4'h0, 32'h0);
    for (int l = 0; l < 16; l++) begin
      dbg_irq_active = l[3];
      cpu_irq_level = l[2:0];
      @(negedge mclk);
      chk({31'h0, irq_allow}, {31'h0, !l[3] || l[2:0] >= 3'h5});
    end
    dbg_irq_active = 1'b0;
  endtask
  task automatic t_trace;
    int n;
    int beats;
    int idle;
    trace_word = 32'h1234_5678;
    trace_valid = 1'b1;
    @(negedge mclk);
    trace_valid = 1'b0;
    n = 0;
    while (proc_status_bus !== 4'h8 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    for (int k = 7; k >= 0; k--) begin
      chk({28'h0, trace_data_bus}, {28'h0, trace_word[4*k+:4]});
      repeat (2) @(negedge mclk);
    end
    // Fill the buffer while the port drains it slowly, then let it empty.
    // Beats are counted from the first push, as draining starts at once.
    n = 0;
    beats = 0;
    idle = 0;
    trace_valid = 1'b1;
    while (trace_ready === 1'b1 && n < 40) begin
      trace_word = 32'(n);
      @(negedge mclk);
      beats += (proc_status_bus === 4'h8);
      n++;
    end
    trace_valid = 1'b0;
    chk({31'h0, n >= 16 && n <= 18}, 32'h1);
    for (int m = 0; m < 800 && idle < 20; m++) begin
      @(negedge mclk);
      beats += (proc_status_bus === 4'h8);
      idle = (proc_status_bus === 4'h8) ? 0 : idle + 1;
    end
    chk(32'(beats), 32'(n * 16));
    cpu_halted = 1'b1;
    repeat (3) @(negedge mclk);
    chk({27'h0, all_status_high, proc_status_bus}, 32'h1f);
    cpu_halted = 1'b0;
    cpu_status = 4'hf;
    repeat (3) @(negedge mclk);
    chk({27'h0, all_status_high, proc_status_bus}, 32'h0);
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ====================================================================
  // Main sequence
  initial begin
    {cpu_addr, cpu_data, cpu_pc, cpu_reg_wdata, trace_word} = '0;
    {cpu_addr_valid, cpu_data_valid, cpu_pc_valid, cpu_reg_wr} = 4'h0;
    {cpu_reg_rd, cpu_halted, dbg_irq_active, trace_valid} = 4'h0;
    {cpu_reg_idx, cpu_status, cpu_irq_level} = 11'h0;
    cpu_supervisor = 1'b1;
    arst_n = 1'b0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_regs;
    t_serial;
    t_trig;
    t_irq;
    t_trace;
    end_of_test;
  end
endmodule // cdbt_core_debug_test
